// [logic/refsel_top.sv]
// Input reference monitoring, validation and selection for two tracking loops
//
// Functional notes
// - Each 128 ms window, a drift beyond 500 ppm adds one to the input's bucket.
// - Bucket decreases by one per full decay period with no drift event.
// - Four bucket profiles (size, upper, lower, decay); 2-bit selector per input.
// - Bucket saturates at the chosen profile's size.
// - Idle flag sets above upper threshold, clears below lower threshold.
// - Idle inputs are excluded from selection for both loops.
// - Offset meter reference is system clock or primary loop output, by a bit.
// - Severe accept/reject limits are (nibble plus one) times the offset scale.
// - Severe flag sets above reject limit, clears below accept limit.
// - Mild flag behaves alike using its own 8-bit limit field.
// - Severe flag disqualifies the input; mild flag never affects selection.
// - 8-bit measured offset per input is readable; times scale gives ppm.
// - Choice code 0 is automatic, 3-6 force inputs 1-4, 9-a force 5-6.
// - Forced choice routes the input regardless of any alarm or validity.
// - Automatic choice takes the qualified input with the highest rank.
// - Active-low participation bit resets disabled; software clears it to enable.
// - Primary validity: no idle, severe, lock timeout, loss pin or rapid drop.
// - Secondary validity: no idle, severe flag or associated loss pin.
// - Validity change in either direction sets a toggle flag; flag requests interrupt.
// - Chosen input going valid to invalid sets failed flag; flag requests interrupt.
// - A high associated loss pin disqualifies the input; none associated at reset.
// - Primary lock timeout flags and disqualifies the selected input.
`timescale 1ns/100ps
`default_nettype none

module refsel_top
	import refsel_pkg::*;
#(
	parameter int WINDOW_CYCLES = WINDOW_CYC,
	parameter int MS_CYCLES     = TICK_CYC
) (
	input  wire logic        CLOCK,       // System clock, 200 MHz
	input  wire logic        RESETN,      // Synchronous reset, active low
	input  wire logic        PSEL,        // APB select
	input  wire logic        PENABLE,     // APB enable
	input  wire logic        PWRITE,      // APB direction
	input  wire logic [7:0]  PADDR,       // APB byte address
	input  wire logic [31:0] PWDATA,      // APB write data
	output logic      [31:0] PRDATA,      // APB read data
	output logic             PREADY,      // APB ready
	output logic             PSLVERR,     // APB error on unmapped address
	input  wire logic [5:0]  REF_EDGE,    // Per-input edge seen pulse
	input  wire logic [5:0]  REF_MISS,    // Per-input expected edge missed pulse
	input  wire logic [47:0] OFFSET_SYS,  // Offset codes against system clock
	input  wire logic [47:0] OFFSET_LOOP, // Offset codes against primary loop
	input  wire logic [3:0]  LOSS_PIN,    // Asynchronous loss-of-signal pins
	input  wire logic        PRI_LOCKED,  // Asynchronous primary loop lock status
	output logic      [3:0]  PRI_SEL,     // Primary loop input number, 0 none
	output logic      [3:0]  SEC_SEL,     // Secondary loop input number, 0 none
	output logic             IRQ          // Interrupt request, high while a toggle or failed flag is set
);

	function automatic logic [3:0] forced_index(input logic [3:0] code);
		if (code >= CODE_F1_LO && code <= CODE_F1_HI) begin
			return code - CODE_F1_ADJ;
		end else if (code >= CODE_F5_LO && code <= CODE_F5_HI) begin
			return code - CODE_F5_ADJ;
		end
		return 4'h0;
	endfunction

	function automatic logic [3:0] pick_best(input logic [5:0] ok, input logic [23:0] ranks);
		logic [3:0] best;
		logic [3:0] num;
		logic       found;
		best  = 4'h0;
		num   = 4'h0;
		found = 1'b0;
		for (int k = 0; k < NUM_IN; k++) begin
			if (ok[k] && (!found || ranks[4*k+:4] > best)) begin
				best  = ranks[4*k+:4];
				num   = 4'(k + 1);
				found = 1'b1;
			end
		end
		return num;
	endfunction

	function automatic logic [5:0] sel_mask(input logic [3:0] sel);
		logic [5:0] m;
		m = 6'h00;
		for (int k = 0; k < NUM_IN; k++) begin
			if (sel == 4'(k + 1)) begin
				m[k] = 1'b1;
			end
		end
		return m;
	endfunction

	logic [7:0]  ctrl_ff;
	logic [15:0] limits_ff;
	logic [25:0] prof_ff [4];
	logic [11:0] prof_sel_ff;
	logic [5:0]  part_dis_n_ff;
	logic [23:0] los_map_ff;
	logic [23:0] rank_ff;
	logic [7:0]  pri_code_ff;
	logic [7:0]  tmo_ff;
	logic [5:0]  lock_to_ff;
	logic [5:0]  pri_tog_ff;
	logic [5:0]  sec_tog_ff;
	logic        pri_fail_ff;
	logic        sec_fail_ff;
	logic [5:0]  pri_valid_ff;
	logic [5:0]  sec_valid_ff;
	logic [3:0]  pri_sel_ff;
	logic [3:0]  sec_sel_ff;
	logic [3:0]  prev_sel_ff;
	logic [3:0]  los_meta_ff;
	logic [3:0]  los_sync_ff;
	logic        lock_meta_ff;
	logic        lock_sync_ff;
	logic [31:0] win_cnt_ff;
	logic [31:0] ms_cnt_ff;
	logic        win_tick_ff;
	logic        ms_tick_ff;
	logic [7:0]  lt_ms_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic        irq_ff;

	logic [5:0]  idle_w;
	logic [5:0]  severe_w;
	logic [5:0]  mild_w;
	logic [5:0]  dropped_w;
	logic [47:0] offs_w;
	logic [5:0]  nxt_pri_valid;
	logic [5:0]  nxt_sec_valid;
	logic [3:0]  nxt_pri_sel;
	logic [3:0]  nxt_sec_sel;
	logic [31:0] rd_data;
	logic        rd_err;
	logic [3:0]  scale;
	logic        wr_en;
	logic [5:0]  lock_set;

	assign scale = ctrl_ff[CTRL_SCALE+:4];
	assign wr_en = PSEL && PENABLE && PWRITE && pready_ff;

	// Two-stage synchronisers for asynchronous pins
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			los_meta_ff  <= 4'h0;
			los_sync_ff  <= 4'h0;
			lock_meta_ff <= 1'b0;
			lock_sync_ff <= 1'b0;
		end else begin
			los_meta_ff  <= LOSS_PIN;
			los_sync_ff  <= los_meta_ff;
			lock_meta_ff <= PRI_LOCKED;
			lock_sync_ff <= lock_meta_ff;
		end
	end

	// Monitoring window and millisecond tick
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			win_cnt_ff  <= 32'h0;
			win_tick_ff <= 1'b0;
			ms_cnt_ff   <= 32'h0;
			ms_tick_ff  <= 1'b0;
		end else begin
			win_tick_ff <= (win_cnt_ff == 32'(WINDOW_CYCLES - 1));
			win_cnt_ff  <= (win_cnt_ff == 32'(WINDOW_CYCLES - 1)) ? 32'h0 : win_cnt_ff + 32'h1;
			ms_tick_ff  <= (ms_cnt_ff == 32'(MS_CYCLES - 1));
			ms_cnt_ff   <= (ms_cnt_ff == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt_ff + 32'h1;
		end
	end

	for (genvar i = 0; i < NUM_IN; i++) begin : g_in
		logic [7:0]  acc_ff;
		logic [3:0]  decay_cnt_ff;
		logic        seen_ff;
		logic        idle_ff;
		logic        severe_ff;
		logic        mild_ff;
		logic [7:0]  offs_ff;
		logic [1:0]  miss_ff;
		logic [7:0]  offset;
		logic [11:0] ppm;
		logic        drift;
		logic        event_hit;
		logic [25:0] prof;
		logic [3:0]  decay_len;
		logic [8:0]  sev_acc;
		logic [8:0]  sev_rej;
		logic [8:0]  mild_acc;
		logic [8:0]  mild_rej;

		assign offset    = ctrl_ff[CTRL_REFCH] ? OFFSET_LOOP[8*i+:8] : OFFSET_SYS[8*i+:8];
		assign ppm       = 12'(offset) * 12'(scale);
		assign drift     = ppm > DRIFT_PPM;
		assign event_hit = seen_ff | drift;
		assign prof      = prof_ff[prof_sel_ff[2*i+:2]];
		assign decay_len = 4'h1 << prof[PROF_DECAY+:2];
		assign sev_acc   = 9'(limits_ff[7:4] + 5'h1) * 9'(scale);
		assign sev_rej   = 9'(limits_ff[3:0] + 5'h1) * 9'(scale);
		assign mild_acc  = 9'(limits_ff[LIM_MILD+4+:4] + 5'h1) * 9'(scale);
		assign mild_rej  = 9'(limits_ff[LIM_MILD+:4] + 5'h1) * 9'(scale);

		// Leaky bucket: drift seen in a window fills, quiet decay periods drain
		always_ff @(posedge CLOCK) begin
			if (!RESETN) begin
				acc_ff       <= 8'h00;
				decay_cnt_ff <= 4'h0;
				seen_ff      <= 1'b0;
			end else if (win_tick_ff) begin
				seen_ff <= 1'b0;
				if (event_hit) begin
					decay_cnt_ff <= 4'h0;
					if (acc_ff < prof[7:0]) begin
						acc_ff <= acc_ff + 8'h1;
					end
				end else if (decay_cnt_ff + 4'h1 >= decay_len) begin
					decay_cnt_ff <= 4'h0;
					if (acc_ff != 8'h00) begin
						acc_ff <= acc_ff - 8'h1;
					end
				end else begin
					decay_cnt_ff <= decay_cnt_ff + 4'h1;
				end
			end else if (drift) begin
				seen_ff <= 1'b1;
			end
		end

		// Idle and offset alarms with hysteresis
		always_ff @(posedge CLOCK) begin
			if (!RESETN) begin
				idle_ff   <= 1'b0;
				severe_ff <= 1'b0;
				mild_ff   <= 1'b0;
				offs_ff   <= 8'h00;
			end else begin
				offs_ff <= offset;
				if (acc_ff > prof[PROF_UPPER+:8]) begin
					idle_ff <= 1'b1;
				end else if (acc_ff < prof[PROF_LOWER+:8]) begin
					idle_ff <= 1'b0;
				end
				if (ppm > 12'(sev_rej)) begin
					severe_ff <= 1'b1;
				end else if (ppm < 12'(sev_acc)) begin
					severe_ff <= 1'b0;
				end
				if (ppm > 12'(mild_rej)) begin
					mild_ff <= 1'b1;
				end else if (ppm < 12'(mild_acc)) begin
					mild_ff <= 1'b0;
				end
			end
		end

		// Consecutive missed cycles, cleared by any seen edge
		always_ff @(posedge CLOCK) begin
			if (!RESETN) begin
				miss_ff <= 2'h0;
			end else if (REF_EDGE[i]) begin
				miss_ff <= 2'h0;
			end else if (REF_MISS[i] && miss_ff != 2'h3) begin
				miss_ff <= miss_ff + 2'h1;
			end
		end

		assign idle_w[i]      = idle_ff;
		assign severe_w[i]    = severe_ff;
		assign mild_w[i]      = mild_ff;
		assign dropped_w[i]   = ctrl_ff[CTRL_RAPID] && (miss_ff >= MISS_LIMIT);
		assign offs_w[8*i+:8] = offs_ff;
	end

	// Validity per loop; mild flag deliberately absent
	always_comb begin
		for (int k = 0; k < NUM_IN; k++) begin
			nxt_sec_valid[k] = !idle_w[k] && !severe_w[k]
				&& ((los_map_ff[4*k+:4] & los_sync_ff) == 4'h0);
			nxt_pri_valid[k] = nxt_sec_valid[k] && !lock_to_ff[k] && !dropped_w[k];
		end
	end

	// Selection follows registered validity every cycle
	always_comb begin
		if (pri_code_ff[3:0] == CODE_AUTO) begin
			nxt_pri_sel = pick_best(pri_valid_ff & ~part_dis_n_ff, rank_ff);
		end else begin
			nxt_pri_sel = forced_index(pri_code_ff[3:0]);
		end
		if (pri_code_ff[CHOICE_SEC+:4] == CODE_AUTO) begin
			nxt_sec_sel = pick_best(sec_valid_ff & ~part_dis_n_ff, rank_ff);
		end else begin
			nxt_sec_sel = forced_index(pri_code_ff[CHOICE_SEC+:4]);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			pri_valid_ff <= 6'h00;
			sec_valid_ff <= 6'h00;
			pri_sel_ff   <= 4'h0;
			sec_sel_ff   <= 4'h0;
			prev_sel_ff  <= 4'h0;
		end else begin
			pri_valid_ff <= nxt_pri_valid;
			sec_valid_ff <= nxt_sec_valid;
			pri_sel_ff   <= nxt_pri_sel;
			sec_sel_ff   <= nxt_sec_sel;
			prev_sel_ff  <= pri_sel_ff;
		end
	end

	// Lock timeout on the primary loop's selected input
	always_comb begin
		lock_set = 6'h00;
		if (ms_tick_ff && pri_sel_ff != 4'h0 && pri_sel_ff == prev_sel_ff && !lock_sync_ff
			&& tmo_ff != 8'h00 && lt_ms_ff + 8'h1 >= tmo_ff) begin
			lock_set = sel_mask(pri_sel_ff);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			lt_ms_ff <= 8'h00;
		end else if (pri_sel_ff == 4'h0 || pri_sel_ff != prev_sel_ff || lock_sync_ff || lock_set != 6'h00) begin
			lt_ms_ff <= 8'h00;
		end else if (ms_tick_ff && lt_ms_ff != 8'hff) begin
			lt_ms_ff <= lt_ms_ff + 8'h1;
		end
	end

	// Sticky flags; a hardware set wins over a write-one clear
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			lock_to_ff  <= 6'h00;
			pri_tog_ff  <= 6'h00;
			sec_tog_ff  <= 6'h00;
			pri_fail_ff <= 1'b0;
			sec_fail_ff <= 1'b0;
		end else begin
			lock_to_ff <= lock_set
				| (lock_to_ff & ~((wr_en && PADDR == ADDR_ALARM) ? PWDATA[ALARM_LOCK+:6] : 6'h00));
			pri_tog_ff <= (pri_valid_ff ^ nxt_pri_valid)
				| (pri_tog_ff & ~((wr_en && PADDR == ADDR_FLAGS) ? PWDATA[5:0] : 6'h00));
			sec_tog_ff <= (sec_valid_ff ^ nxt_sec_valid)
				| (sec_tog_ff & ~((wr_en && PADDR == ADDR_FLAGS) ? PWDATA[FLAGS_SEC+:6] : 6'h00));
			pri_fail_ff <= ((sel_mask(pri_sel_ff) & pri_valid_ff & ~nxt_pri_valid) != 6'h00)
				|| (pri_fail_ff && !(wr_en && PADDR == ADDR_FLAGS && PWDATA[FLAGS_PFAIL]));
			sec_fail_ff <= ((sel_mask(sec_sel_ff) & sec_valid_ff & ~nxt_sec_valid) != 6'h00)
				|| (sec_fail_ff && !(wr_en && PADDR == ADDR_FLAGS && PWDATA[FLAGS_SFAIL]));
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (pri_tog_ff != 6'h00) || (sec_tog_ff != 6'h00) || pri_fail_ff || sec_fail_ff;
		end
	end

	// Configuration writes take effect at the edge that completes the transfer
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			ctrl_ff       <= CTRL_RST;
			limits_ff     <= LIM_RST;
			prof_sel_ff   <= 12'h000;
			part_dis_n_ff <= PART_RST;
			los_map_ff    <= 24'h000000;
			rank_ff       <= 24'h000000;
			pri_code_ff   <= 8'h00;
			tmo_ff        <= 8'h00;
			for (int p = 0; p < 4; p++) begin
				prof_ff[p] <= PROF_RST;
			end
		end else if (wr_en) begin
			case (PADDR)
				ADDR_CTRL: ctrl_ff <= PWDATA[7:0];
				ADDR_LIMITS: limits_ff <= PWDATA[15:0];
				ADDR_INCFG: begin
					prof_sel_ff   <= PWDATA[11:0];
					part_dis_n_ff <= PWDATA[INCFG_PART+:6];
				end
				ADDR_LOSMAP: los_map_ff <= PWDATA[23:0];
				ADDR_RANK: rank_ff <= PWDATA[23:0];
				ADDR_CHOICE: begin
					pri_code_ff <= PWDATA[7:0];
					tmo_ff      <= PWDATA[CHOICE_TMO+:8];
				end
				default: begin
					for (int p = 0; p < 4; p++) begin
						if (PADDR == ADDR_PROF0 + 8'(4 * p)) begin
							prof_ff[p] <= PWDATA[25:0];
						end
					end
				end
			endcase
		end
	end

	always_comb begin
		rd_data = 32'h0;
		rd_err  = 1'b0;
		case (PADDR)
			ADDR_CTRL: rd_data[7:0] = ctrl_ff;
			ADDR_LIMITS: rd_data[15:0] = limits_ff;
			ADDR_PROF0, ADDR_PROF0 + 8'h4, ADDR_PROF0 + 8'h8, ADDR_PROF0 + 8'hc: rd_data[25:0] = prof_ff[PADDR[3:2] - 2'h2];
			ADDR_INCFG: rd_data = {10'h0, part_dis_n_ff, 4'h0, prof_sel_ff};
			ADDR_LOSMAP: rd_data[23:0] = los_map_ff;
			ADDR_RANK: rd_data[23:0] = rank_ff;
			ADDR_CHOICE: rd_data = {8'h0, tmo_ff, 8'h0, pri_code_ff};
			ADDR_ALARM: rd_data = {2'h0, lock_to_ff, 2'h0, mild_w, 2'h0, severe_w, 2'h0, idle_w};
			ADDR_FLAGS: rd_data = {14'h0, sec_fail_ff, pri_fail_ff, 2'h0, sec_tog_ff, 2'h0, pri_tog_ff};
			ADDR_VALID: rd_data = {8'h0, sec_sel_ff, pri_sel_ff, 2'h0, sec_valid_ff, 2'h0, pri_valid_ff};
			ADDR_OFFS_LO: rd_data = offs_w[31:0];
			ADDR_OFFS_HI: rd_data[15:0] = offs_w[47:32];
			default: rd_err = 1'b1;
		endcase
	end

	// One wait state, then ready with data for one cycle
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= PSEL && PENABLE && !pready_ff;
			pslverr_ff <= PSEL && PENABLE && !pready_ff && rd_err;
			if (PSEL && PENABLE && !pready_ff && !PWRITE) begin
				prdata_ff <= rd_data;
			end
		end
	end

	assign PRDATA  = prdata_ff;
	assign PREADY  = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign PRI_SEL = pri_sel_ff;
	assign SEC_SEL = sec_sel_ff;
	assign IRQ     = irq_ff;

endmodule

`default_nettype wire

// [pkg/refsel_pkg.sv]
// Constants shared by the input reference qualify and select block
package refsel_pkg;

	localparam int NUM_IN        = 6;
	localparam int CLK_FREQ_KHZ  = 200000;
	localparam int WINDOW_MS     = 128;
	localparam int WINDOW_CYC    = WINDOW_MS * CLK_FREQ_KHZ;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYC      = TICK_MS * CLK_FREQ_KHZ;
	localparam int DRIFT_LIMIT   = 500;
	localparam logic [11:0] DRIFT_PPM  = 12'(DRIFT_LIMIT);
	localparam logic [1:0]  MISS_LIMIT = 2'h2;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_LIMITS  = 8'h04;
	localparam logic [7:0] ADDR_PROF0   = 8'h08;
	localparam logic [7:0] ADDR_INCFG   = 8'h18;
	localparam logic [7:0] ADDR_LOSMAP  = 8'h1c;
	localparam logic [7:0] ADDR_RANK    = 8'h20;
	localparam logic [7:0] ADDR_CHOICE  = 8'h24;
	localparam logic [7:0] ADDR_ALARM   = 8'h28;
	localparam logic [7:0] ADDR_FLAGS   = 8'h2c;
	localparam logic [7:0] ADDR_VALID   = 8'h30;
	localparam logic [7:0] ADDR_OFFS_LO = 8'h34;
	localparam logic [7:0] ADDR_OFFS_HI = 8'h38;

	// Field positions
	localparam int CTRL_REFCH  = 0;
	localparam int CTRL_RAPID  = 1;
	localparam int CTRL_NOISE  = 2;
	localparam int CTRL_SCALE  = 4;
	localparam int LIM_MILD    = 8;
	localparam int PROF_UPPER  = 8;
	localparam int PROF_LOWER  = 16;
	localparam int PROF_DECAY  = 24;
	localparam int INCFG_PART  = 16;
	localparam int CHOICE_SEC  = 4;
	localparam int CHOICE_TMO  = 16;
	localparam int ALARM_SEV   = 8;
	localparam int ALARM_MILD  = 16;
	localparam int ALARM_LOCK  = 24;
	localparam int FLAGS_SEC   = 8;
	localparam int FLAGS_PFAIL = 16;
	localparam int FLAGS_SFAIL = 17;
	localparam int VALID_SEC   = 8;
	localparam int VALID_PSEL  = 16;
	localparam int VALID_SSEL  = 20;

	// Reset values
	localparam logic [7:0]  CTRL_RST  = 8'h10;
	localparam logic [15:0] LIM_RST   = 16'h0000;
	localparam logic [25:0] PROF_RST  = 26'h0000000;
	localparam logic [5:0]  PART_RST  = 6'h3f;

	// Reference choice codes
	localparam logic [3:0] CODE_AUTO   = 4'h0;
	localparam logic [3:0] CODE_F1_LO  = 4'h3;
	localparam logic [3:0] CODE_F1_HI  = 4'h6;
	localparam logic [3:0] CODE_F5_LO  = 4'h9;
	localparam logic [3:0] CODE_F5_HI  = 4'ha;
	localparam logic [3:0] CODE_F1_ADJ = 4'h2;
	localparam logic [3:0] CODE_F5_ADJ = 4'h4;

endpackage

// [dv/refsel_props.sv]
// Port-level checker for the input reference qualify and select block
`timescale 1ns/100ps
`default_nettype none

module refsel_props
	import refsel_pkg::*;
#(
	parameter int WINDOW_CYCLES = WINDOW_CYC,
	parameter int MS_CYCLES     = TICK_CYC
) (
	input wire logic        CLOCK,   // System clock
	input wire logic        RESETN,  // Synchronous reset, active low
	input wire logic        PSEL,    // APB select
	input wire logic        PENABLE, // APB enable
	input wire logic        PWRITE,  // APB direction
	input wire logic [7:0]  PADDR,   // APB address
	input wire logic [31:0] PWDATA,  // APB write data
	input wire logic [31:0] PRDATA,  // APB read data
	input wire logic        PREADY,  // APB ready
	input wire logic        PSLVERR, // APB error
	input wire logic [3:0]  PRI_SEL, // Primary loop choice
	input wire logic [3:0]  SEC_SEL, // Secondary loop choice
	input wire logic        IRQ      // Interrupt request
);
	logic [7:0] choice_ff;
	logic [5:0] part_ff;
	logic [3:0] quiet_ff;
	logic       wr_done;

	assign wr_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

	function automatic logic [3:0] code_to_sel(input logic [3:0] c);
		if (c >= CODE_F1_LO && c <= CODE_F1_HI) return c - CODE_F1_ADJ;
		if (c >= CODE_F5_LO && c <= CODE_F5_HI) return c - CODE_F5_ADJ;
		return 4'h0;
	endfunction

	// Shadow of the choice codes and participation bits written over the bus
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			choice_ff <= 8'h00;
			part_ff   <= PART_RST;
		end else begin
			if (wr_done && PADDR == ADDR_CHOICE) choice_ff <= PWDATA[7:0];
			if (wr_done && PADDR == ADDR_INCFG) part_ff <= PWDATA[21:16];
		end
	end

	// Cycles since the last completed write, saturating
	always_ff @(posedge CLOCK) begin
		if (!RESETN || wr_done) quiet_ff <= 4'h0;
		else if (quiet_ff != 4'hf) quiet_ff <= quiet_ff + 4'h1;
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready did not follow the first access cycle");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready stood longer than one cycle");
	err_ready_a: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
		else $error("error raised outside a completing transfer");
	unmapped_err_a: assert property (PREADY && (PADDR[1:0] != 2'b00 || PADDR > ADDR_OFFS_HI) |-> PSLVERR)
		else $error("unmapped address answered without error");
	rdata_hold_a: assert property ($changed(PRDATA) |-> PREADY && !PWRITE)
		else $error("read data changed outside a read completion");
	reset_clear_a: assert property ($rose(RESETN) |-> PRI_SEL == 4'h0 && SEC_SEL == 4'h0 && !IRQ && !PREADY)
		else $error("outputs not cleared by reset");
	pri_force_a: assert property (quiet_ff > 4'h5 && choice_ff[3:0] != CODE_AUTO |-> PRI_SEL == code_to_sel(choice_ff[3:0]))
		else $error("primary choice does not follow its forced code");
	sec_force_a: assert property (quiet_ff > 4'h5 && choice_ff[7:4] != CODE_AUTO |-> SEC_SEL == code_to_sel(choice_ff[7:4]))
		else $error("secondary choice does not follow its forced code");
	auto_none_a: assert property (quiet_ff > 4'h5 && choice_ff == 8'h00 && part_ff == 6'h3f |-> PRI_SEL == 4'h0 ##1 SEC_SEL == 4'h0)
		else $error("input chosen automatically without participation");
endmodule

bind refsel_top refsel_props #(.WINDOW_CYCLES(WINDOW_CYCLES), .MS_CYCLES(MS_CYCLES)) props_u (
	.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRI_SEL(PRI_SEL),
	.SEC_SEL(SEC_SEL), .IRQ(IRQ)
);
`default_nettype wire

// [dv/refsel_partner.sv]
// Model of the reference sources, their offset meters and the loss pins
`timescale 1ns/100ps
`default_nettype none

module refsel_partner (
	input  wire logic        clock,       // System clock
	input  wire logic [47:0] sys_set,     // Offset codes against the system clock
	input  wire logic [47:0] loop_set,    // Offset codes against the primary loop
	input  wire logic [3:0]  loss_set,    // Loss pin levels
	input  wire logic [5:0]  stop_set,    // Inputs whose edges stop arriving
	input  wire logic        lock_set,    // Primary loop lock level
	output logic      [5:0]  ref_edge,    // Edge seen pulses
	output logic      [5:0]  ref_miss,    // Missed edge pulses
	output logic      [47:0] offset_sys,  // Meter codes against the system clock
	output logic      [47:0] offset_loop, // Meter codes against the primary loop
	output logic      [3:0]  loss_pin,    // Loss pins
	output logic             pri_locked   // Primary loop lock status
);
	logic phase_ff = 1'b0;

	initial begin
		{ref_edge, ref_miss, offset_sys, offset_loop, loss_pin} = '0;
		pri_locked = 1'b1;
	end

	// Clocks of live inputs give an edge every other cycle; stopped ones miss it
	always @(posedge clock) begin
		phase_ff    <= !phase_ff;
		ref_edge    <= ~stop_set & {6{phase_ff}};
		ref_miss    <= stop_set & {6{phase_ff}};
		offset_sys  <= sys_set;
		offset_loop <= loop_set;
		loss_pin    <= loss_set;
		pri_locked  <= lock_set;
	end
endmodule
`default_nettype wire

// [dv/input_reference_qualify_select_bench.sv]
// Self-checking bench for the input reference qualify and select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, seen, exp) begin samples_checked++; if ((seen) !== (exp)) begin fails++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen); end end

module input_reference_qualify_select_bench
	import refsel_pkg::*;
;
	typedef struct packed { logic w; logic e; logic [31:0] d; } note_type;
	logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, pri_locked, irq, lock_set = 1'b1;
	logic [5:0]  ref_edge, ref_miss, stop_set = 6'h0;
	logic [47:0] offset_sys, offset_loop, sys_set = 48'h0, loop_set = 48'h0;
	logic [3:0]  loss_pin, loss_set = 4'h0, pri_sel, sec_sel;
	logic [3:0]  rank [6];
	note_type    notes [$];
	int          fails = 0, samples_checked = 0, cyc = 0, top, nxt;
	integer      seed = 32'h4f80be4f;

	always #2.5 clock = ~clock;

	refsel_top #(.WINDOW_CYCLES(20), .MS_CYCLES(5)) dut_u (
		.CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .REF_EDGE(ref_edge),
		.REF_MISS(ref_miss), .OFFSET_SYS(offset_sys), .OFFSET_LOOP(offset_loop), .LOSS_PIN(loss_pin),
		.PRI_LOCKED(pri_locked), .PRI_SEL(pri_sel), .SEC_SEL(sec_sel), .IRQ(irq)
	);
	refsel_partner partner_u (
		.clock(clock), .sys_set(sys_set), .loop_set(loop_set), .loss_set(loss_set), .stop_set(stop_set),
		.ref_edge(ref_edge), .ref_miss(ref_miss), .offset_sys(offset_sys), .offset_loop(offset_loop),
		.loss_pin(loss_pin), .pri_locked(pri_locked), .lock_set(lock_set)
	);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// One APB transfer; the expected answer goes to the note queue
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic e);
		notes.push_back('{w: w, e: e, d: x});
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic sel_is(input logic [3:0] p, input logic [3:0] s);
		int k;
		repeat (8) @(posedge clock);
		for (k = 0; k < 30 && (pri_sel !== p || sec_sel !== s); k++) @(posedge clock);
		`CHK("pri_sel", pri_sel, p)
		`CHK("sec_sel", sec_sel, s)
	endtask

	function automatic logic [3:0] forced(input logic [3:0] c);
		return (c inside {[4'h3:4'h6]}) ? c - 4'h2 : (c inside {4'h9, 4'ha}) ? c - 4'h4 : 4'h0;
	endfunction

	function automatic int best(input logic [5:0] elig);
		int i;
		int b;
		b = 0;
		for (i = 0; i < 6; i++) if (elig[i] && (b == 0 || rank[i] > rank[b - 1])) b = i + 1;
		return b;
	endfunction

	always @(posedge clock) begin
		note_type n;
		if (resetn && psel && penable && pready === 1'b1) begin
			n = notes.pop_front();
			if (!n.w) `CHK("prdata", prdata, n.d)
			`CHK("pslverr", pslverr, n.e)
		end
	end

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end

	initial begin
		int i;
		int j;
		int c;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		apb(0, ADDR_CTRL, 0, {24'h0, CTRL_RST}, 0);
		apb(0, ADDR_INCFG, 0, 32'(PART_RST) << INCFG_PART, 0);
		apb(0, ADDR_LOSMAP, 0, 0, 0);
		apb(0, ADDR_ALARM, 0, 0, 0);
		apb(1, 8'h3c, 32'h5a5a5a5a, 0, 1);
		apb(0, 8'h3c, 0, 0, 1);
		apb(0, 8'h01, 0, 0, 1);
		// Forced codes win over a lost input that does not participate
		apb(1, ADDR_LOSMAP, 32'h1, 0, 0);
		loss_set <= 4'h1;
		for (c = 0; c < 16; c++) begin
			apb(1, ADDR_CHOICE, {24'h0, 4'(c), 4'(c)}, 0, 0);
			sel_is(forced(4'(c)), forced(4'(c)));
		end
		for (i = 0; i < 6; i++) begin
			rank[i] = 4'($random(seed));
			for (j = 0; j < i; j++) if (rank[j] == rank[i]) begin
				rank[i] = rank[i] + 4'h1;
				j = -1;
			end
		end
		apb(1, ADDR_RANK, {8'h0, rank[5], rank[4], rank[3], rank[2], rank[1], rank[0]}, 0, 0);
		apb(1, ADDR_CHOICE, 0, 0, 0);
		apb(1, ADDR_INCFG, 0, 0, 0);
		top = best(6'h3e);
		sel_is(4'(top), 4'(top));
		loss_set <= 4'h0;
		top = best(6'h3f);
		nxt = best(6'h3f & ~(6'h1 << (top - 1)));
		sel_is(4'(top), 4'(top));
		apb(1, ADDR_FLAGS, 32'hffffffff, 0, 0);
		apb(0, ADDR_FLAGS, 0, 0, 0);
		`CHK("irq", irq, 1'b0)
		// Mild offset leaves the choice alone, severe offset moves it
		apb(1, ADDR_LIMITS, 32'h0014, 0, 0);
		sys_set[8 * (top - 1) +: 8] <= 8'h03;
		sel_is(4'(top), 4'(top));
		apb(0, ADDR_ALARM, 0, 32'h1 << (ALARM_MILD + top - 1), 0);
		sys_set[8 * (top - 1) +: 8] <= 8'h06;
		sel_is(4'(nxt), 4'(nxt));
		apb(0, ADDR_ALARM, 0, 32'h101 << (ALARM_SEV + top - 1), 0);
		apb(0, ADDR_FLAGS, 0, (32'h101 << (top - 1)) | 32'h30000, 0);
		`CHK("irq", irq, 1'b1)
		apb(0, top > 4 ? ADDR_OFFS_HI : ADDR_OFFS_LO, 0, 32'h6 << (8 * ((top - 1) % 4)), 0);
		apb(1, ADDR_CTRL, 32'h11, 0, 0);
		sel_is(4'(top), 4'(top));
		apb(1, ADDR_CTRL, 32'h10, 0, 0);
		sel_is(4'(nxt), 4'(nxt));
		sys_set[8 * (top - 1) +: 8] <= 8'h03;
		sel_is(4'(nxt), 4'(nxt));
		sys_set[8 * (top - 1) +: 8] <= 8'h01;
		sel_is(4'(top), 4'(top));
		// Missed edges drop only the primary loop's choice
		apb(1, ADDR_CTRL, 32'h16, 0, 0);
		stop_set[top - 1] <= 1'b1;
		sel_is(4'(nxt), 4'(top));
		stop_set <= 6'h0;
		sel_is(4'(top), 4'(top));
		// Bucket fills up to its size, then drains past its lower threshold
		sys_set <= 48'h0;
		// Lock loss times out every primary candidate in turn
		apb(1, ADDR_CHOICE, 32'h20000, 0, 0);
		lock_set <= 1'b0;
		repeat (100) @(posedge clock);
		sel_is(4'h0, 4'(top));
		lock_set <= 1'b1;
		apb(1, ADDR_CHOICE, 0, 0, 0);
		apb(1, ADDR_ALARM, 32'h3f000000, 0, 0);
		apb(0, ADDR_ALARM, 0, 0, 0);
		apb(1, ADDR_PROF0, 32'h00010103, 0, 0);
		apb(1, ADDR_CTRL, 32'h20, 0, 0);
		sys_set[7:0] <= 8'hff;
		repeat (110) @(posedge clock);
		apb(0, ADDR_ALARM, 0, 32'h00010101, 0);
		sys_set[7:0] <= 8'h00;
		repeat (30) @(posedge clock);
		apb(0, ADDR_ALARM, 0, 32'h1, 0);
		repeat (62) @(posedge clock);
		apb(0, ADDR_ALARM, 0, 32'h0, 0);
		end_sim();
	end
endmodule
`default_nettype wire
